// ==== hw/tfc_regs.sv ====
// tx flow control request registers with an axi4-lite slave
// ------------------------------------------------------------
// Behaviour
// R1 - a queue's request acts only while its flow enable bit is 1.
// R2 - in 2-bit mode register requests drive a queue only if its source bit selects registers.
// R3 - in 1-bit mode low is idle, rise gives xoff, held high repeats xoff, fall gives xon.
// R4 - in 1-bit mode each queue's request comes only from the low request field.
// R5 - in 2-bit mode codes decode as 00 none, 01 xon, 10 xoff, 11 invalid.
// R6 - the field from bit 16 gives the upper code bit, the low field the lower bit.
// R7 - both request fields take writes at any time and act at once.
// R8 - with pause reaction set a valid received pause halts user transmit, else not.
// R9 - software sets the pause reaction bit only while transmit is idle.
// R10 - generated frames use a 48-bit destination whose low 32 bits come from one register.
// R11 - the upper 16 destination bits come from bits 15:0 of the next register.
// R12 - a per-queue enable field lets only enabled queues generate frames.
// R13 - bit 16 of the mode register selects 1-bit (0) or 2-bit (1) mode for all queues.
// R14 - in 2-bit mode a source bit of 0 takes external inputs, 1 the register fields.
// R15 - reserved bits and words read zero and ignore writes.
// ------------------------------------------------------------
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tfc_regs #(
    parameter int QN = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [QN-1:0] ext_insert_low,
    input wire logic [QN-1:0] ext_insert_high,
    input wire logic pause_frame_rx,
    input wire logic tx_idle,
    output logic [QN-1:0] xoff_request,
    output logic [QN-1:0] xon_request,
    output logic user_tx_halt,
    output logic [47:0] pause_dest_addr
);
    import tfc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_idx;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [QN-1:0] enable;
        logic [QN-1:0] req_low;
        logic [QN-1:0] req_high;
        logic [QN-1:0] req_low_prev;
        logic two_bit_mode;
        logic [QN-1:0] src_reg;
        logic pause_react;
        logic [31:0] dest_low;
        logic [15:0] dest_high;
        logic [QN-1:0] xoff;
        logic [QN-1:0] xon;
        logic halt;
    } tfc_state_s;

    tfc_state_s st_reg;
    tfc_state_s st_next;

    function automatic logic [31:0] tfc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : tfc_merge

    function automatic logic [31:0] tfc_read(input tfc_state_s s,
                                           input logic [11:0] idx,
                                           output logic hit);
        logic [31:0] v;
        v = 32'h0000_0000;
        hit = 1'b1;
        unique case (idx)
            IDX_FLOW_ENABLE: v[QN-1:0] = s.enable;
            IDX_FLOW_REQUEST_BITS: begin
                v[QN-1:0] = s.req_low;
                v[REQ_HIGH_LSB +: QN] = s.req_high;
            end
            IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D,
            IDX_RSVD_E: v = 32'h0000_0000; // [R15]
            IDX_PAUSE_REACTION_CONTROL: v[PAUSE_REACT_BIT] = s.pause_react;
            IDX_PAUSE_DEST_ADDR_LOW: v = s.dest_low;
            IDX_PAUSE_DEST_ADDR_HIGH: v[DEST_HIGH_WIDTH-1:0] = s.dest_high;
            IDX_REQUEST_MODE: begin
                v[QN-1:0] = s.src_reg;
                v[MODE_SEL_BIT] = s.two_bit_mode;
            end
            IDX_PAUSE_STATUS: begin
                v[0] = s.halt;
                v[1] = tx_idle;
            end
            default: hit = 1'b0;
        endcase
        return v;
    endfunction : tfc_read

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic hit;
        logic [1:0] code;
        logic rq;
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        hit = 1'b0;
        code = 2'h0;
        rq = 1'b0;
        st_next = st_reg;

        // write address and data may arrive in either order
        if (s_axi_awvalid && !st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_idx = s_axi_awaddr[13:2];
        end
        if (s_axi_wvalid && !st_reg.w_held) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            // writes take effect any time, traffic running or not [R7]
            unique case (st_reg.aw_idx)
                IDX_FLOW_ENABLE: begin
                    wv = tfc_merge({{(32-QN){1'b0}}, st_reg.enable},
                                   st_reg.w_data, st_reg.w_strb);
                    st_next.enable = wv[QN-1:0]; // [R12]
                end
                IDX_FLOW_REQUEST_BITS: begin
                    wv = tfc_merge(32'h0000_0000, st_reg.w_data,
                                   st_reg.w_strb);
                    wv[QN-1:0] = st_reg.w_strb[0] ?
                                 st_reg.w_data[QN-1:0] : st_reg.req_low;
                    wv[REQ_HIGH_LSB +: QN] = st_reg.w_strb[2] ?
                        st_reg.w_data[REQ_HIGH_LSB +: QN] : st_reg.req_high;
                    st_next.req_low = wv[QN-1:0];
                    st_next.req_high = wv[REQ_HIGH_LSB +: QN]; // [R6]
                end
                IDX_PAUSE_REACTION_CONTROL: begin
                    // software keeps this to idle periods [R9]
                    if (st_reg.w_strb[0]) begin
                        st_next.pause_react =
                            st_reg.w_data[PAUSE_REACT_BIT];
                    end
                end
                IDX_PAUSE_DEST_ADDR_LOW: begin
                    st_next.dest_low = tfc_merge(st_reg.dest_low,
                        st_reg.w_data, st_reg.w_strb); // [R10]
                end
                IDX_PAUSE_DEST_ADDR_HIGH: begin
                    wv = tfc_merge({16'h0000, st_reg.dest_high},
                                   st_reg.w_data, st_reg.w_strb);
                    st_next.dest_high = wv[DEST_HIGH_WIDTH-1:0]; // [R11]
                end
                IDX_REQUEST_MODE: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.src_reg = st_reg.w_data[QN-1:0]; // [R14]
                    end
                    if (st_reg.w_strb[2]) begin
                        st_next.two_bit_mode =
                            st_reg.w_data[MODE_SEL_BIT]; // [R13]
                    end
                end
                IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D, IDX_RSVD_E,
                IDX_PAUSE_STATUS: ; // [R15]
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end

        if (s_axi_rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_reg.rvalid) begin
            rv = tfc_read(st_reg, s_axi_araddr[13:2], hit);
            st_next.rvalid = 1'b1;
            st_next.rdata = rv;
            st_next.rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // per-queue request decode
        for (int q = 0; q < QN; q++) begin
            st_next.xoff[q] = 1'b0;
            st_next.xon[q] = 1'b0;
            if (st_reg.two_bit_mode) begin
                // code from the selected source [R2] [R14] [R6]
                code = st_reg.src_reg[q] ?
                       {st_reg.req_high[q], st_reg.req_low[q]} :
                       {ext_insert_high[q], ext_insert_low[q]};
                st_next.xon[q] = (code == TFC_REQ_XON); // [R5]
                st_next.xoff[q] = (code == TFC_REQ_XOFF); // [R5]
            end else begin
                rq = st_reg.req_low[q]; // [R4]
                st_next.xoff[q] = rq; // [R3]
                st_next.xon[q] = st_reg.req_low_prev[q] && !rq; // [R3]
            end
            if (!st_reg.enable[q]) begin
                st_next.xoff[q] = 1'b0; // [R1]
                st_next.xon[q] = 1'b0; // [R1]
            end
        end
        st_next.req_low_prev = st_reg.req_low;

        // halt tracks each received pause indication while pause_react is set [R8]
        st_next.halt = st_reg.pause_react && pause_frame_rx;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.enable <= '1;
            st_reg.req_low <= RST_REQUEST_BITS[QN-1:0];
            st_reg.req_high <= RST_REQUEST_BITS[REQ_HIGH_LSB +: QN];
            st_reg.pause_react <= RST_PAUSE_REACTION[PAUSE_REACT_BIT];
            st_reg.dest_low <= RST_DEST_LOW;
            st_reg.dest_high <= RST_DEST_HIGH;
            st_reg.src_reg <= RST_REQUEST_MODE[QN-1:0];
            st_reg.two_bit_mode <= RST_REQUEST_MODE[MODE_SEL_BIT];
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_held;
    assign s_axi_wready = !st_reg.w_held;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign xoff_request = st_reg.xoff;
    assign xon_request = st_reg.xon;
    assign user_tx_halt = st_reg.halt;
    assign pause_dest_addr = {st_reg.dest_high, st_reg.dest_low}; // [R10]
endmodule : tfc_regs

// ==== include/tfc_pkg.sv ====
// package of register map, fields and codes for the tx flow control block
package tfc_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_FLOW_ENABLE = 12'h0605;
    localparam logic [11:0] IDX_FLOW_REQUEST_BITS = 12'h0606;
    localparam logic [11:0] IDX_RSVD_A = 12'h0607;
    localparam logic [11:0] IDX_RSVD_B = 12'h0608;
    localparam logic [11:0] IDX_RSVD_C = 12'h0609;
    localparam logic [11:0] IDX_PAUSE_REACTION_CONTROL = 12'h060a;
    localparam logic [11:0] IDX_RSVD_D = 12'h060b;
    localparam logic [11:0] IDX_RSVD_E = 12'h060c;
    localparam logic [11:0] IDX_PAUSE_DEST_ADDR_LOW = 12'h060d;
    localparam logic [11:0] IDX_PAUSE_DEST_ADDR_HIGH = 12'h060e;
    localparam logic [11:0] IDX_REQUEST_MODE = 12'h0641;
    localparam logic [11:0] IDX_PAUSE_STATUS = 12'h0700;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int REQ_HIGH_LSB = 16;
    localparam int MODE_SEL_BIT = 16;
    localparam int PAUSE_REACT_BIT = 0;
    localparam int DEST_HIGH_WIDTH = 16;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_REQUEST_BITS = 32'h0000_0000;
    localparam logic [31:0] RST_PAUSE_REACTION = 32'h0000_0000;
    localparam logic [31:0] RST_DEST_LOW = 32'hc200_0001;
    localparam logic [15:0] RST_DEST_HIGH = 16'h0180;
    localparam logic [31:0] RST_REQUEST_MODE = 32'h0000_0000;
    // ------------------------------------------------------------
    // request codes and bus answers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TFC_REQ_NONE = 2'h0,
        TFC_REQ_XON = 2'h1,
        TFC_REQ_XOFF = 2'h2,
        TFC_REQ_INVALID = 2'h3
    } tfc_code_e;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tfc_pkg

// ==== testbench/tfc_properties.sv ====
// concurrent checks on the ports of tfc_regs
`timescale 1ns/1ps
module tfc_properties #(
    parameter int QN = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pause_frame_rx,
    input wire logic [QN-1:0] xoff_request,
    input wire logic [QN-1:0] xon_request,
    input wire logic user_tx_halt,
    input wire logic [47:0] pause_dest_addr
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_halt_cause;
        user_tx_halt |-> $past(pause_frame_rx);
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("halt without a received pause");
    property p_dest_reset;
        $rose(aresetn) |-> pause_dest_addr == 48'h0180_c200_0001;
    endproperty
    a_dest_reset: assert property (p_dest_reset)
        else $error("destination address reset value wrong");
    property p_code_excl;
        (xon_request & xoff_request) == '0;
    endproperty
    a_code_excl: assert property (p_code_excl)
        else $error("xon and xoff together on one queue");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data late");
    property p_b_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stands: assert property (p_b_stands)
        else $error("write response dropped early");
    property p_r_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stands: assert property (p_r_stands)
        else $error("read data dropped early");
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse)
        else $error("read address taken while data pending");
endmodule : tfc_properties

bind tfc_regs tfc_properties #(.QN(QN)) u_props (.*);

// ==== testbench/tb_top.sv ====
// self-checking bench for tfc_regs
`timescale 1ns/1ps
module tb_top;
    import tfc_pkg::*;
    localparam int QN = 8;
    logic aclk = 0, aresetn = 0, tx_idle = 1, pause_frame_rx = 0, xclr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, user_tx_halt;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, lo, hi, m, src, e;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
    logic [QN-1:0] ext_insert_low = '0, ext_insert_high = '0;
    logic [QN-1:0] xoff_request, xon_request, xacc, sl, sh;
    logic [47:0] pause_dest_addr;
    logic [33:0] rq[$];
    int fail_count = 0, comparisons = 0, xcnt;
    logic [11:0] ri [12] = '{12'h605, 12'h606, 12'h607, 12'h608, 12'h609,
        12'h60a, 12'h60b, 12'h60c, 12'h60d, 12'h60e, 12'h641, 12'h7ff};
    logic [31:0] rv [12] = '{32'hff, 0, 0, 0, 0, 0, 0, 0,
        32'hc200_0001, 32'h180, 0, 0};
    logic [11:0] wi [5] = '{12'h607, 12'h606, 12'h60a, 12'h641, 12'h60e};
    logic [31:0] wx [5] = '{0, 32'h00ff_00ff, 1, 32'h0001_00ff, 32'hffff};

    always #25 aclk = ~aclk;
    tfc_regs #(.QN(QN)) dut (.*);

    task automatic chk(input logic [47:0] s, input logic [47:0] x);
        comparisons++;
        if (s !== x) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, s, x);
        end
    endtask : chk

    task tally_and_finish;
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // bus master: valid held until its ready edge
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] i, input logic [31:0] v);
        logic a, w;
        a = 0;
        w = 0;
        bq.push_back(RESP_OKAY);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) a = 1;
            if (s_axi_wvalid && s_axi_wready) w = 1;
            if (a) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask : wr

    task automatic rd(input logic [11:0] i, input logic [31:0] x);
        rq.push_back({i == 12'h7ff ? RESP_SLVERR : RESP_OKAY, x});
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        @(posedge aclk);
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask : rd

    // results are compared in order of issue; xon pulses are tallied
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
        if (xclr) begin
            xacc <= '0;
            xcnt <= 0;
        end else if (xon_request != '0) begin
            xacc <= xacc | xon_request;
            xcnt <= xcnt + 1;
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        d = $urandom(32'he95e_37b8);
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk(pause_dest_addr, 48'h0180_c200_0001);
        foreach (ri[k]) rd(ri[k], rv[k]);
        foreach (wi[k]) begin
            wr(wi[k], '1);
            rd(wi[k], wx[k]);
        end
        d = $urandom;
        hi = $urandom;
        wr(IDX_PAUSE_DEST_ADDR_LOW, d);
        wr(IDX_PAUSE_DEST_ADDR_HIGH, hi);
        chk(pause_dest_addr, {hi[15:0], d});
        pause_frame_rx <= 1;
        repeat (2) @(posedge aclk);
        chk(user_tx_halt, 1);
        rd(IDX_PAUSE_STATUS, 32'h3);
        wr(IDX_PAUSE_REACTION_CONTROL, 0);
        repeat (2) @(posedge aclk);
        chk(user_tx_halt, 0);
        pause_frame_rx <= 0;
        // mixed sources, every code, random enables, checked three cycles after the last write completes
        repeat (8) begin
            {lo, hi, m, src, e} = {$urandom, $urandom, $urandom, $urandom, $urandom};
            ext_insert_low <= e[7:0];
            ext_insert_high <= e[15:8];
            wr(IDX_FLOW_ENABLE, m);
            wr(IDX_REQUEST_MODE, src | 32'h0001_0000);
            wr(IDX_FLOW_REQUEST_BITS, {hi[15:0], lo[15:0]});
            repeat (3) @(posedge aclk);
            sl = (lo[7:0] & src[7:0]) | (e[7:0] & ~src[7:0]);
            sh = (hi[7:0] & src[7:0]) | (e[15:8] & ~src[7:0]);
            chk(xoff_request, sh & ~sl & m[7:0]);
            chk(xon_request, sl & ~sh & m[7:0]);
        end
        wr(IDX_REQUEST_MODE, 0);
        repeat (4) begin
            {lo, m} = {$urandom, $urandom};
            wr(IDX_FLOW_ENABLE, m);
            wr(IDX_FLOW_REQUEST_BITS, lo);
            repeat (3) @(posedge aclk);
            chk(xoff_request, lo[7:0] & m[7:0]);
            chk(xon_request, 0);
            xclr <= 1;
            @(posedge aclk);
            xclr <= 0;
            wr(IDX_FLOW_REQUEST_BITS, 0);
            repeat (3) @(posedge aclk);
            chk(xacc, lo[7:0] & m[7:0]);
            chk(xcnt, (lo[7:0] & m[7:0]) != 0);
            chk(xoff_request, 0);
        end
        tally_and_finish;
    end
endmodule : tb_top
